// ---- hdl/can_ffs_regs.svh ----
// register offsets, field positions, mode codes, reset values and bus level of the
// fifo filter, filter support, sleep and test-mode block.
// assumes a 32-bit ahb-lite register window with word-aligned registers.
`ifndef CAN_FFS_REGS_SVH
`define CAN_FFS_REGS_SVH

// byte offsets inside the block's window
`define OFF_CHANNEL_CONTROL 8'h00
`define OFF_CHANNEL_STATUS 8'h04
`define OFF_FIFO_MASK_A 8'h08
`define OFF_FIFO_MASK_B 8'h0C
`define OFF_FIFO_COMPARE_ID_A 8'h10
`define OFF_FIFO_COMPARE_ID_B 8'h14
`define OFF_FILTER_SUPPORT 8'h18
`define OFF_FILTER_RESULT 8'h1C

// channel_control_reg fields
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 1
`define CTL_SLEEP_BIT 2
`define CTL_TEST_LSB 3
`define CTL_TEST_MSB 4
`define CTL_ID_FORMAT_SELECT_BIT 5
`define CTL_FIFO_MODE_BIT 6
`define CTL_WIDTH 7

// operating mode request codes
`define MODE_OPERATE 2'b00
`define MODE_RESET 2'b01
`define MODE_HALT 2'b10

// test mode codes
`define TEST_NONE 2'b00
`define TEST_LISTEN_ONLY 2'b01
`define TEST_EXT_LOOPBACK 2'b10
`define TEST_INT_LOOPBACK 2'b11

// compare id / mask layout: ide, rtr, then sid10..0 and eid17..0
`define ID_IDE_BIT 31
`define ID_RTR_BIT 30
`define ID_MSB 28
`define STD_ID_MSB 28
`define STD_ID_LSB 18
`define STD_UPPER_LSB 21

// reset values: the channel leaves reset in reset mode
`define CONTROL_RESET 7'h01
`define WORD_RESET 32'h0000_0000

// recessive level on the bus
`define CAN_RECESSIVE 1'b1

`endif

// ---- hdl/can_ffs_pkg.sv ----
// types shared by the fifo filter, sleep and test-mode block.
// the numeric constants live in can_ffs_regs.svh.
package can_ffs_pkg;

  // states reported on the status register
  typedef enum logic [2:0] {
    ST_RESET,
    ST_HALT,
    ST_OPERATE,
    ST_SLEEP
  } chan_state_e;

  typedef logic [31:0] word_t;

endpackage : can_ffs_pkg

// ---- hdl/fifo_accept_match.sv ----
// one compare-id / mask pair of the receive fifo acceptance filter.
// purely combinational; the parent registers everything it drives out.
`timescale 1ns/100ps
`include "can_ffs_regs.svh"

module fifo_accept_match (
  // received frame identity
  input wire can_ffs_pkg::word_t rx_word,
  // one filter pair and the format selection
  input wire can_ffs_pkg::word_t compare_id,
  input wire can_ffs_pkg::word_t mask,
  input wire logic id_format_select,
  // judgement of this pair
  output logic hit
);
  import can_ffs_pkg::*;

  logic id_ok;
  logic rtr_ok;
  logic ide_ok;

  // a mask bit of 0 drops the id bit, a 1 demands equality
  assign id_ok = (((rx_word[`ID_MSB:0] ^ compare_id[`ID_MSB:0]) & mask[`ID_MSB:0]) == 29'h0);
  // remote request bit is never masked
  assign rtr_ok = (rx_word[`ID_RTR_BIT] == compare_id[`ID_RTR_BIT]);
  // extended flag joins the compare only in mixed format
  assign ide_ok = !id_format_select || (rx_word[`ID_IDE_BIT] == compare_id[`ID_IDE_BIT]);
  assign hit = id_ok && rtr_ok && ide_ok;

endmodule : fifo_accept_match

// ---- hdl/can_fifo_filter_sleep_test.sv ----
// can channel slice: receive fifo acceptance filter, filter support register,
// sleep entry and wakeup, and the three test modes, behind an ahb-lite slave.
// assumes a protocol controller on hclk that reports finished frames as a
// one-cycle strobe and drives its internal transmit bit; pins go to a transceiver.
//
// Contract
// - fifo mode compares against two compare ids
// - mask 0 ignores bit, 1 compares
// - judgement 0 discards, 1 stores
// - remote request bit always compared
// - extended flag compared only in mixed mode
// - every reception loads filter support register (code: only standard-id receptions outside sleep)
// - read gives upper byte and one-hot low
// - filter support handles standard ids only
// - sleep gates the module clock off
// - clearing sleep returns to prior mode
// - halt waits for running frame to end
// - test codes 01 listen, 10 ext, 11 int
// - listen-only receives, sends only recessive
// - external loopback stores own frames, self-acks
// - internal loopback feeds tx to rx
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`include "can_ffs_regs.svh"

module can_fifo_filter_sleep_test (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire can_ffs_pkg::word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output can_ffs_pkg::word_t hrdata,
  output logic hresp,
  // protocol controller side
  input wire logic rx_frame_valid,
  input wire can_ffs_pkg::word_t rx_frame_id,
  input wire logic frame_busy,
  input wire logic ctl_tx_bit,
  output logic ctl_rx_bit,
  output logic self_ack_en,
  output logic bus_drive_inhibit,
  output logic own_frame_receive,
  // receive fifo write port
  output logic fifo_store,
  output can_ffs_pkg::word_t fifo_store_id,
  // clock gate for the module clock
  output logic module_clk_en,
  // transceiver pins
  input wire logic can_rx_pin,
  output logic can_tx_pin
);
  import can_ffs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage and state

  logic [`CTL_WIDTH-1:0] channel_control_reg_r;
  word_t fifo_mask_a_r;
  word_t fifo_mask_b_r;
  word_t fifo_compare_id_a_r;
  word_t fifo_compare_id_b_r;
  logic [10:0] filter_support_reg_r;
  logic last_judgement_r;
  logic last_valid_r;
  chan_state_e state_r;
  chan_state_e state_nxt;
  chan_state_e pre_sleep_r;

  // ahb address phase capture
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_ok;
  logic rd_take;
  logic wr_take;

  // pin synchroniser
  logic rx_meta_r;
  logic rx_sync_r;

  // decoded control fields
  logic [1:0] mode_req;
  logic sleep_req;
  logic [1:0] test_mode_select;
  logic id_format_select;
  logic fifo_mode;
  logic hit_a;
  logic hit_b;
  logic judgement;
  logic [7:0] one_hot_low;

  // decodes an id's low three standard bits to one of eight columns
  function automatic logic [7:0] decode_low(input logic [2:0] low3);
    logic [7:0] v;
    v = 8'h00;
    v[low3] = 1'b1;
    return v;
  endfunction : decode_low

  // true when an ahb address phase addresses a register word inside the window
  function automatic logic in_window(input logic [31:0] a);
    return (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00) && (a[7:0] <= `OFF_FILTER_RESULT);
  endfunction : in_window

  assign mode_req = channel_control_reg_r[`CTL_MODE_MSB:`CTL_MODE_LSB];
  assign sleep_req = channel_control_reg_r[`CTL_SLEEP_BIT];
  assign test_mode_select = channel_control_reg_r[`CTL_TEST_MSB:`CTL_TEST_LSB];
  assign id_format_select = channel_control_reg_r[`CTL_ID_FORMAT_SELECT_BIT];
  assign fifo_mode = channel_control_reg_r[`CTL_FIFO_MODE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, writes land at the data-phase edge

  assign addr_ok = hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite && in_window(haddr);

  // the slave never stalls and always answers okay; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // address phase of a write is held until its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= haddr[7:0];
    end
  end

  // read data is registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `WORD_RESET;
    end else if (rd_take && in_window(haddr)) begin
      case (haddr[7:0])
        `OFF_CHANNEL_CONTROL: hrdata <= {25'h0, channel_control_reg_r};
        `OFF_CHANNEL_STATUS: hrdata <= {27'h0, frame_busy, state_r == ST_SLEEP, state_r == ST_OPERATE,
                                        state_r == ST_HALT, state_r == ST_RESET};
        `OFF_FIFO_MASK_A: hrdata <= fifo_mask_a_r;
        `OFF_FIFO_MASK_B: hrdata <= fifo_mask_b_r;
        `OFF_FIFO_COMPARE_ID_A: hrdata <= fifo_compare_id_a_r;
        `OFF_FIFO_COMPARE_ID_B: hrdata <= fifo_compare_id_b_r;
        // upper byte as received, low three bits as one-hot column
        `OFF_FILTER_SUPPORT: hrdata <= {16'h0, filter_support_reg_r[10:3], one_hot_low};
        `OFF_FILTER_RESULT: hrdata <= {30'h0, last_valid_r, last_judgement_r};
        default: hrdata <= `WORD_RESET;
      endcase
    end else begin
      hrdata <= `WORD_RESET;
    end
  end

  assign one_hot_low = decode_low(filter_support_reg_r[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers

  // control writes are taken in any state, so clearing sleep can wake the channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_control_reg_r <= `CONTROL_RESET;
    end else if (wr_pend_r && wr_addr_r == `OFF_CHANNEL_CONTROL) begin
      channel_control_reg_r <= hwdata[`CTL_WIDTH-1:0];
    end
  end

  // filter pairs: mask a goes with compare id a, mask b with compare id b
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_mask_a_r <= `WORD_RESET;
      fifo_mask_b_r <= `WORD_RESET;
      fifo_compare_id_a_r <= `WORD_RESET;
      fifo_compare_id_b_r <= `WORD_RESET;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `OFF_FIFO_MASK_A: fifo_mask_a_r <= hwdata;
        `OFF_FIFO_MASK_B: fifo_mask_b_r <= hwdata;
        `OFF_FIFO_COMPARE_ID_A: fifo_compare_id_a_r <= hwdata;
        `OFF_FIFO_COMPARE_ID_B: fifo_compare_id_b_r <= hwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode state machine

  // halt and reset wait for a running frame; sleep is only honoured from
  // reset or halt, and wakeup returns to the mode remembered at entry
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP: begin
        if (!sleep_req) begin
          state_nxt = pre_sleep_r;
        end
      end
      ST_RESET, ST_HALT: begin
        if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end else if (mode_req == `MODE_OPERATE) begin
          state_nxt = ST_OPERATE;
        end else if (mode_req == `MODE_RESET) begin
          state_nxt = ST_RESET;
        end else if (mode_req == `MODE_HALT) begin
          state_nxt = ST_HALT;
        end
      end
      ST_OPERATE: begin
        if (!frame_busy) begin
          if (mode_req == `MODE_RESET) begin
            state_nxt = ST_RESET;
          end else if (mode_req == `MODE_HALT) begin
            state_nxt = ST_HALT;
          end
        end
      end
      default: state_nxt = ST_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // remember where sleep was entered from
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_sleep_r <= ST_RESET;
    end else if (state_r != ST_SLEEP && state_nxt == ST_SLEEP) begin
      pre_sleep_r <= state_r;
    end
  end

  // clock gate enable: low for the whole of sleep; the register file and this
  // state machine stay on hclk so software can still wake the channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_clk_en <= 1'b1;
    end else begin
      module_clk_en <= (state_nxt != ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo acceptance filter

  fifo_accept_match u_match_a (
    .rx_word(rx_frame_id),
    .compare_id(fifo_compare_id_a_r),
    .mask(fifo_mask_a_r),
    .id_format_select(id_format_select),
    .hit(hit_a)
  );

  fifo_accept_match u_match_b (
    .rx_word(rx_frame_id),
    .compare_id(fifo_compare_id_b_r),
    .mask(fifo_mask_b_r),
    .id_format_select(id_format_select),
    .hit(hit_b)
  );

  // either pair accepting is enough; mailbox ids play no part here
  assign judgement = hit_a || hit_b;

  // a frame is stored only on a positive judgement, and never while asleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_store <= 1'b0;
      fifo_store_id <= `WORD_RESET;
    end else begin
      fifo_store <= rx_frame_valid && fifo_mode && judgement && (state_r != ST_SLEEP);
      if (rx_frame_valid) begin
        fifo_store_id <= rx_frame_id;
      end
    end
  end

  // last judgement kept for software diagnosis of the filter setup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_judgement_r <= 1'b0;
      last_valid_r <= 1'b0;
    end else if (rx_frame_valid && fifo_mode && state_r != ST_SLEEP) begin
      last_judgement_r <= judgement;
      last_valid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter support register

  // every standard-id reception outside sleep overwrites it, whatever the judgement;
  // extended frames and reads leave it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_support_reg_r <= 11'h000;
    end else if (rx_frame_valid && !rx_frame_id[`ID_IDE_BIT] && state_r != ST_SLEEP) begin
      filter_support_reg_r <= rx_frame_id[`STD_ID_MSB:`STD_ID_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and test modes

  // the receive pin is asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta_r <= `CAN_RECESSIVE;
      rx_sync_r <= `CAN_RECESSIVE;
    end else begin
      rx_meta_r <= can_rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // transmit pin: recessive in listen-only and internal loopback, and while
  // the channel is asleep or in reset so the bus is never disturbed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_tx_pin <= `CAN_RECESSIVE;
    end else if (state_r == ST_SLEEP || state_r == ST_RESET) begin
      can_tx_pin <= `CAN_RECESSIVE;
    end else begin
      case (test_mode_select)
        `TEST_LISTEN_ONLY: can_tx_pin <= `CAN_RECESSIVE;
        `TEST_INT_LOOPBACK: can_tx_pin <= `CAN_RECESSIVE;
        default: can_tx_pin <= ctl_tx_bit;
      endcase
    end
  end

  // receive path: internal loopback takes the controller's own bit and
  // ignores the pin; the others listen to the synchronised pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_rx_bit <= `CAN_RECESSIVE;
    end else if (test_mode_select == `TEST_INT_LOOPBACK) begin
      ctl_rx_bit <= ctl_tx_bit;
    end else begin
      ctl_rx_bit <= rx_sync_r;
    end
  end

  // protocol controller steering: self-ack and own-frame storage in both
  // loopbacks, no ack/overload/error flags in listen-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_ack_en <= 1'b0;
      own_frame_receive <= 1'b0;
      bus_drive_inhibit <= 1'b0;
    end else begin
      self_ack_en <= (test_mode_select == `TEST_EXT_LOOPBACK) || (test_mode_select == `TEST_INT_LOOPBACK);
      own_frame_receive <= (test_mode_select == `TEST_EXT_LOOPBACK) || (test_mode_select == `TEST_INT_LOOPBACK);
      bus_drive_inhibit <= (test_mode_select == `TEST_LISTEN_ONLY);
    end
  end

endmodule : can_fifo_filter_sleep_test

// ---- test/can_ffs_properties.sv ----
// concurrent checks on the ports of the fifo filter, sleep and test-mode slice.
// assumes a bind onto can_fifo_filter_sleep_test; sees nothing but its ports.
`timescale 1ns/100ps

module can_ffs_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire can_ffs_pkg::word_t hrdata,
  input wire logic hresp,
  // receive side
  input wire logic rx_frame_valid,
  input wire can_ffs_pkg::word_t rx_frame_id,
  input wire logic fifo_store,
  input wire can_ffs_pkg::word_t fifo_store_id,
  // mode and pins
  input wire logic module_clk_en,
  input wire logic bus_drive_inhibit,
  input wire logic self_ack_en,
  input wire logic own_frame_receive,
  input wire logic can_rx_pin,
  input wire logic ctl_rx_bit,
  input wire logic can_tx_pin
);
  import can_ffs_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // two edges asleep, so a store launched just before the gate is not blamed
  sequence s_asleep;
    !module_clk_en ##1 !module_clk_en;
  endsequence
  // pin path only judged once the loopback select has settled for a while
  sequence s_pin_path;
    !self_ack_en [*4];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_store_cause: assert property (fifo_store |-> $past(rx_frame_valid) && $past(module_clk_en))
    else $error("fifo store without an awake reception");
  chk_store_id: assert property (fifo_store |-> fifo_store_id == $past(rx_frame_id))
    else $error("stored id differs from received id");
  chk_sleep_quiet: assert property (s_asleep |-> can_tx_pin && !fifo_store)
    else $error("activity while asleep");
  chk_listen_recessive: assert property (bus_drive_inhibit |-> can_tx_pin)
    else $error("dominant bit driven in listen-only");
  chk_listen_excl: assert property (bus_drive_inhibit |-> !self_ack_en)
    else $error("listen-only and loopback both selected");
  chk_ack_pair: assert property (own_frame_receive == self_ack_en)
    else $error("self ack and own receive disagree");
  chk_pin_sync: assert property (s_pin_path |-> ctl_rx_bit == $past(can_rx_pin, 3))
    else $error("receive bit not the pin three edges back");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");

endmodule : can_ffs_properties

bind can_fifo_filter_sleep_test can_ffs_properties u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .rx_frame_valid, .rx_frame_id, .fifo_store, .fifo_store_id, .module_clk_en,
  .bus_drive_inhibit, .self_ack_en, .own_frame_receive, .can_rx_pin, .ctl_rx_bit, .can_tx_pin);

// ---- test/can_bus_node.sv ----
// transceiver plus one remote node on a wired-and bus.
// assumes the bench says when the remote node pulls the bus dominant.
`timescale 1ns/100ps

module can_bus_node (
  // local transceiver
  input wire logic can_tx_pin,
  output logic can_rx_pin,
  // remote node
  input wire logic node_dom
);
  // dominant wins; the pin sees our own bits, so external loopback closes here
  assign can_rx_pin = can_tx_pin & ~node_dom;
endmodule : can_bus_node

// ---- test/test_can_fifo_filter_sleep_test.sv ----
// self-checking bench: register bus tasks, filter table, test modes and sleep.
// assumes a zero-wait slave and the partner on the transceiver pins.
`timescale 1ns/100ps
`include "can_ffs_regs.svh"

module test_can_fifo_filter_sleep_test;
  import can_ffs_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_frame_valid, frame_busy, ctl_tx_bit;
  logic ctl_rx_bit, self_ack_en, bus_drive_inhibit, own_frame_receive, fifo_store, module_clk_en;
  logic can_rx_pin, can_tx_pin, node_dom;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  word_t hwdata, hrdata, rx_frame_id, fifo_store_id, rd, fs_exp;
  int miscompares, checks;
  // matches a: 0x123 and 0x122 data; matches b: 0x6f3 remote only
  localparam word_t frame_ids [0:7] = '{32'h048C_0000, 32'h0488_0000, 32'h0484_0000, 32'h448C_0000,
    32'h5BCC_0000, 32'h1BCC_0000, 32'h848C_0000, 32'h048C_0055};
  localparam logic [7:0] frame_hit = 8'b1101_0011;

  can_fifo_filter_sleep_test DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_frame_valid, .rx_frame_id, .frame_busy, .ctl_tx_bit,
    .ctl_rx_bit, .self_ack_en, .bus_drive_inhibit, .own_frame_receive, .fifo_store, .fifo_store_id,
    .module_clk_en, .can_rx_pin, .can_tx_pin);
  can_bus_node u_node (.can_tx_pin, .can_rx_pin, .node_dom);

  ////////////////////////////////////////////////////////////////////////////
  task chk(input word_t got, input word_t exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // address phase held until hready is seen high at a rising edge, then the
  // data phase likewise; read data is taken at that same rising edge
  task ahb_xfer(input logic [7:0] a, input logic wr, input word_t d, output word_t q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb_xfer

  task ahb_write(input logic [7:0] a, input word_t d);
    word_t q;
    ahb_xfer(a, 1'b1, d, q);
  endtask : ahb_write

  task ahb_read(input logic [7:0] a, output word_t q);
    ahb_xfer(a, 1'b0, 32'h0000_0000, q);
  endtask : ahb_read

  // status is polled with a bound instead of assuming a settle time
  task wait_state(input logic [3:0] st);
    int n;
    n = 0;
    ahb_read(`OFF_CHANNEL_STATUS, rd);
    while (rd[3:0] !== st && n < 20) begin
      ahb_read(`OFF_CHANNEL_STATUS, rd);
      n++;
    end
    chk({28'h000_0000, rd[3:0]}, {28'h000_0000, st});
  endtask : wait_state

  // one finished frame; upd says whether the support register should follow
  task rx_check(input word_t id, input logic hit, input logic upd);
    @(posedge hclk);
    rx_frame_valid <= 1'b1; rx_frame_id <= id;
    @(posedge hclk);
    rx_frame_valid <= 1'b0;
    @(negedge hclk);
    chk({31'h0000_0000, fifo_store}, {31'h0000_0000, hit});
    if (upd && !id[31]) fs_exp = {16'h0000, id[28:21], 8'h01 << id[20:18]};
    ahb_read(`OFF_FILTER_SUPPORT, rd);
    chk(rd, fs_exp);
  endtask : rx_check

  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; rx_frame_valid = 1'b0; rx_frame_id = '0; frame_busy = 1'b0; ctl_tx_bit = 1'b1;
    node_dom = 1'b0; miscompares = 0; checks = 0; fs_exp = 32'h0000_0001;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, read-only support register and an unmapped word
    ahb_write(`OFF_FILTER_SUPPORT, 32'h0000_FFFF);
    for (int i = 0; i < 9; i++) begin
      ahb_read(8'(i * 4), rd);
      chk(rd, (i == 0 || i == 1 || i == 6) ? 32'h0000_0001 : 32'h0000_0000);
    end
    ahb_write(`OFF_FIFO_MASK_A, 32'h1FF8_0000);
    ahb_write(`OFF_FIFO_MASK_B, 32'h1FFC_0000);
    ahb_write(`OFF_FIFO_COMPARE_ID_A, 32'h048C_0000);
    ahb_write(`OFF_FIFO_COMPARE_ID_B, 32'h5BCC_0000);
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0041);
    for (int i = 0; i < 8; i++) rx_check(frame_ids[i], frame_hit[i], 1'b1);
    // mixed format: the extended flag now takes part
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0061);
    rx_check(frame_ids[6], 1'b0, 1'b1);
    rx_check(frame_ids[0], 1'b1, 1'b1);
    // fifo mode off: no store, support register still loaded
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0001);
    rx_check(32'h0034_0000, 1'b0, 1'b1);
    // halt waits for the running frame; only operate can have one running
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0000);
    wait_state(4'b0100);
    frame_busy <= 1'b1;
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0002);
    repeat (5) @(posedge hclk);
    wait_state(4'b0100);
    // no frame runs while the test modes are tried
    frame_busy <= 1'b0;
    wait_state(4'b0010);
    for (int t = 1; t < 4; t++) begin
      ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0002 | (t << 3));
      ctl_tx_bit <= (t == 3);
      node_dom <= (t != 2);
      repeat (6) @(posedge hclk);
      @(negedge hclk);
      chk({bus_drive_inhibit, self_ack_en, own_frame_receive}, {t == 1, t > 1, t > 1});
      chk(can_tx_pin, t != 2);
      chk(ctl_rx_bit, t == 3);
    end
    ctl_tx_bit <= 1'b1;
    node_dom <= 1'b0;
    // sleep from halt, wake back to halt; sleep from reset, wake back to reset
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0046);
    wait_state(4'b1000);
    chk(module_clk_en, 1'b0);
    rx_check(frame_ids[0], 1'b0, 1'b0);
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0003);
    wait_state(4'b0010);
    chk(module_clk_en, 1'b1);
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0001);
    wait_state(4'b0001);
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0005);
    wait_state(4'b1000);
    ahb_write(`OFF_CHANNEL_CONTROL, 32'h0000_0003);
    wait_state(4'b0001);
    finish_test();
  end

endmodule : test_can_fifo_filter_sleep_test
